// ### logic/i2ct_cfg.svh
`ifndef I2CT_CFG_SVH
`define I2CT_CFG_SVH

// ================================================================
// bus geometry
`define I2CT_AW 8
`define I2CT_DW 32

// ================================================================
// register indices; byte address is four times the index
`define I2CT_IDX_SCL_PERIOD 6'h0d
`define I2CT_IDX_CONTROL 6'h10
`define I2CT_IDX_STATUS 6'h11

// ================================================================
// scl_period_control fields and reset
`define I2CT_SCL_RESET 16'h0204
`define I2CT_LOW_LSB 0
`define I2CT_HIGH_LSB 8
`define I2CT_CNT_W 8
`define I2CT_LOW_MIN 8'h04

// ================================================================
// control and status bit positions
`define I2CT_CTL_ROLE_BIT 0
`define I2CT_STA_BUSY_BIT 0
`define I2CT_STA_SCL_BIT 1
`define I2CT_STA_RUN_BIT 2

// ================================================================
// bus answers
`define I2CT_RESP_OKAY 2'b00
`define I2CT_RESP_SLVERR 2'b10

`endif

// ### logic/i2ct_pkg.sv
package i2ct_pkg;

    // ================================================================
    // scl generator phases, gray along idle-low-high-low
    typedef enum logic [1:0] {
        I2CT_ST_IDLE = 2'b00,
        I2CT_ST_LOW = 2'b01,
        I2CT_ST_HIGH = 2'b11
    } i2ct_scl_state_t;

    typedef logic [1:0] i2ct_resp_t;

endpackage : i2ct_pkg

// ### logic/i2ct_scl_if.sv
`timescale 1ns/1ps

interface i2ct_scl_if #(
    parameter int CNT_W = 8
);
    logic run;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic drive_low;
    logic rise_pls;
    logic active;

    modport gen (
        input run,
        input low_cnt,
        input high_cnt,
        output drive_low,
        output rise_pls,
        output active
    );

    modport ctl (
        output run,
        output low_cnt,
        output high_cnt,
        input drive_low,
        input rise_pls,
        input active
    );
endinterface : i2ct_scl_if

// ### logic/i2ct_scl_gen.sv
`timescale 1ns/1ps

module i2ct_scl_gen import i2ct_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic mclk,
    input wire logic srst,
    i2ct_scl_if.gen sif
);

    i2ct_scl_state_t state_r;
    i2ct_scl_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic drive_low_r;
    logic rise_r;

    // ================================================================
    // phase sequencing; each phase lasts its count plus one clock
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            I2CT_ST_IDLE: begin
                if (sif.run) begin
                    state_nxt = I2CT_ST_LOW;
                    cnt_nxt = sif.low_cnt;
                end
            end
            I2CT_ST_LOW: begin
                if (!sif.run) begin
                    state_nxt = I2CT_ST_IDLE;
                end else if (cnt_r == '0) begin
                    state_nxt = I2CT_ST_HIGH;
                    cnt_nxt = sif.high_cnt;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            I2CT_ST_HIGH: begin
                if (!sif.run) begin
                    state_nxt = I2CT_ST_IDLE;
                end else if (cnt_r == '0) begin
                    state_nxt = I2CT_ST_LOW;
                    cnt_nxt = sif.low_cnt;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = I2CT_ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= I2CT_ST_IDLE;
            cnt_r <= '0;
            drive_low_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            drive_low_r <= (state_nxt == I2CT_ST_LOW);
            rise_r <= (state_r == I2CT_ST_LOW) && (state_nxt == I2CT_ST_HIGH);
        end
    end

    assign sif.drive_low = drive_low_r;
    assign sif.rise_pls = rise_r;
    assign sif.active = (state_r != I2CT_ST_IDLE);

endmodule : i2ct_scl_gen

// ### logic/i2ct_top.sv
`timescale 1ns/1ps
`include "i2ct_cfg.svh"

// ================================================================

module i2ct_top import i2ct_pkg::*; #(
    parameter int CNT_W = `I2CT_CNT_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [`I2CT_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`I2CT_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`I2CT_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`I2CT_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic link_clk,
    input wire logic link_frame_start,
    input wire logic link_frame_stop,
    output logic link_busy,
    output logic [7:0] link_scl_edges
);

    // ================================================================
    // register state
    logic [15:0] scl_period_r;
    logic role_master_r;

    // generator carrier, declared early because the status read looks at it
    i2ct_scl_if #(.CNT_W(CNT_W)) sif ();

    // ================================================================
    // write channel: address and data taken in either order
    logic aw_have_r;
    logic w_have_r;
    logic [`I2CT_AW-1:0] aw_addr_r;
    logic [`I2CT_DW-1:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic busy_sys;

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_idx = aw_addr_r[`I2CT_AW-1:2];
    assign rd_idx = s_axi_araddr[`I2CT_AW-1:2];

    // write decode; status is read-only but its writes still answer okay
    logic wr_hit;
    logic scl_wr_en;
    logic role_wr_en;

    assign wr_hit = (wr_idx == `I2CT_IDX_SCL_PERIOD) || (wr_idx == `I2CT_IDX_CONTROL)
        || (wr_idx == `I2CT_IDX_STATUS);
    // busy is the synced copy, so a write racing a frame start may still land
    assign scl_wr_en = wr_fire && (wr_idx == `I2CT_IDX_SCL_PERIOD) && !busy_sys;
    assign role_wr_en = wr_fire && (wr_idx == `I2CT_IDX_CONTROL) && w_strb_r[0];

    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    // unmapped addresses answer with slverr; a blocked timing write still answers okay
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `I2CT_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_hit) begin
                s_axi_bresp <= `I2CT_RESP_OKAY;
            end else begin
                s_axi_bresp <= `I2CT_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ================================================================
    // timing register
    always_ff @(posedge mclk) begin
        if (srst) begin
            scl_period_r <= `I2CT_SCL_RESET;
        end else if (scl_wr_en) begin
            if (w_strb_r[0]) begin
                scl_period_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
                scl_period_r[15:8] <= w_data_r[15:8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            role_master_r <= 1'b0;
        end else if (role_wr_en) begin
            role_master_r <= w_data_r[`I2CT_CTL_ROLE_BIT];
        end
    end

    // ================================================================
    // pin and cross-domain inputs: three stages, a change counts when
    // stages two and three agree
    logic [1:0] in_s1_r;
    logic [1:0] in_s2_r;
    logic [1:0] in_s3_r;
    logic [1:0] in_filt_r;
    logic busy_link_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            // idle levels: scl released high, no frame; avoids a false busy after reset
            in_s1_r <= 2'h2;
            in_s2_r <= 2'h2;
            in_s3_r <= 2'h2;
            in_filt_r <= 2'h2;
        end else begin
            in_s1_r <= {scl_i, busy_link_r};
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
            in_filt_r <= (in_s2_r & ~(in_s2_r ^ in_s3_r)) | (in_filt_r & (in_s2_r ^ in_s3_r));
        end
    end

    assign busy_sys = in_filt_r[0];

    // ================================================================
    // read channel
    logic [`I2CT_DW-1:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (rd_idx)
            `I2CT_IDX_SCL_PERIOD: rd_word[15:0] = scl_period_r;
            `I2CT_IDX_CONTROL: rd_word[`I2CT_CTL_ROLE_BIT] = role_master_r;
            `I2CT_IDX_STATUS: begin
                rd_word[`I2CT_STA_BUSY_BIT] = busy_sys;
                rd_word[`I2CT_STA_SCL_BIT] = in_filt_r[1];
                rd_word[`I2CT_STA_RUN_BIT] = sif.active;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `I2CT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `I2CT_RESP_OKAY : `I2CT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ================================================================
    // scl generator
    logic [CNT_W-1:0] low_field;

    assign low_field = scl_period_r[`I2CT_LOW_LSB +: CNT_W];
    // generator only ever runs as master, so the floor applies whenever it runs
    assign sif.low_cnt = (low_field < CNT_W'(`I2CT_LOW_MIN)) ? CNT_W'(`I2CT_LOW_MIN) : low_field;
    assign sif.high_cnt = scl_period_r[`I2CT_HIGH_LSB +: CNT_W];
    assign sif.run = role_master_r && busy_sys;

    i2ct_scl_gen #(.CNT_W(CNT_W)) u_gen (
        .mclk(mclk),
        .srst(srst),
        .sif(sif)
    );

    // open drain: only ever pull low
    assign scl_o = 1'b0;
    assign scl_oe = sif.drive_low;

    // ================================================================
    // rise event to link domain as a toggle
    logic rise_tgl_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rise_tgl_r <= 1'b0;
        end else if (sif.rise_pls) begin
            rise_tgl_r <= !rise_tgl_r;
        end
    end

    // ================================================================
    // link domain: frame flag and scl edge count
    logic [2:0] lrst_s_r;
    logic link_rst_r;
    logic link_rst;
    logic tg_s1_r;
    logic tg_s2_r;
    logic tg_s3_r;
    logic [7:0] edge_cnt_r;

    // reset only reaches this side while the link clock runs; it
    // takes effect once stages two and three agree
    always_ff @(posedge link_clk) begin
        lrst_s_r <= {lrst_s_r[1:0], srst};
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s_r[1] == lrst_s_r[2]) begin
            link_rst_r <= lrst_s_r[1];
        end
    end

    assign link_rst = link_rst_r;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            busy_link_r <= 1'b0;
        end else if (link_frame_start) begin
            busy_link_r <= 1'b1;
        end else if (link_frame_stop) begin
            busy_link_r <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_s3_r <= 1'b0;
        end else begin
            tg_s1_r <= rise_tgl_r;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            edge_cnt_r <= '0;
        end else if (link_frame_start) begin
            edge_cnt_r <= '0;
        end else if (tg_s2_r != tg_s3_r) begin
            edge_cnt_r <= edge_cnt_r + 8'h01;
        end
    end

    assign link_busy = busy_link_r;
    assign link_scl_edges = edge_cnt_r;

endmodule : i2ct_top

// ### tb/i2ct_scl_bus.sv
`timescale 1ns/1ps

// ================================================================
// scl wire seen by the controller
// only a pull-up: the slaves here never stretch the clock
module i2ct_scl_bus (
    input wire logic scl_o,
    input wire logic scl_oe,
    output logic scl_i
);
    assign scl_i = scl_oe ? scl_o : 1'b1;
endmodule : i2ct_scl_bus

// ### tb/i2ct_sva.sv
`timescale 1ns/1ps
`include "i2ct_cfg.svh"

module i2ct_sva #(
    parameter int CNT_W = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_o,
    input wire logic scl_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // ================================================================
    // role shadow; assumes address and data taken together
    logic role_r;
    logic wr_both;
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge mclk) begin
        if (srst) begin
            role_r <= 1'b0;
        end else if (wr_both && s_axi_awaddr == {`I2CT_IDX_CONTROL, 2'b00}) begin
            role_r <= s_axi_wdata[0];
        end
    end

    // ================================================================
    // properties
    property p_low_min;
        $rose(scl_oe) |=> scl_oe [*4];
    endproperty
    a_low_min: assert property (p_low_min) else $error("scl low shorter than five");
    property p_scl_o;
        scl_oe |-> scl_o == 1'b0;
    endproperty
    a_scl_o: assert property (p_scl_o) else $error("scl driven high");
    property p_rst;
        $fell(srst) |-> !scl_oe && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_wr_ans;
        wr_both |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_slave_quiet;
        !role_r && !$past(role_r, 3) |-> !scl_oe;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("scl driven as slave");

    c_scl: cover property ($rose(scl_oe));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == `I2CT_RESP_SLVERR);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : i2ct_sva

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "i2ct_cfg.svh"

module testbench;
    localparam logic [7:0] A_SCL = {`I2CT_IDX_SCL_PERIOD, 2'b00};
    localparam logic [7:0] A_CTL = {`I2CT_IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_STA = {`I2CT_IDX_STATUS, 2'b00};
    logic mclk, srst, link_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic link_frame_start, link_frame_stop, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, scl_i, scl_o, scl_oe, link_busy;
    logic [7:0] s_axi_awaddr, s_axi_araddr, link_scl_edges;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int error_cnt, check_count, cyc, oe_cnt;

    i2ct_top dut_u (.*);
    i2ct_scl_bus bus_u (.*);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (scl_oe === 1'b1) oe_cnt <= oe_cnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    // ================================================================
    // helpers
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // ready sampled at negedge equals its value at the next edge
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge mclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge mclk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task lpulse(input bit stop);
        @(posedge link_clk);
        if (stop) link_frame_stop <= 1'b1;
        else link_frame_start <= 1'b1;
        @(posedge link_clk);
        link_frame_stop <= 1'b0;
        link_frame_start <= 1'b0;
    endtask : lpulse
    task wait_busy(input logic v);
        do axi_rd(A_STA, rd, rs);
        while (rd[0] !== v);
    endtask : wait_busy
    task rst;
        srst <= 1'b1;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
    endtask : rst

    // ================================================================
    // scenarios
    task t_reset;
        axi_rd(A_SCL, rd, rs);
        chk(rd, 32'h0000_0204);
        axi_rd(A_CTL, rd, rs);
        chk(rd, 32'h0);
        axi_rd(A_STA, rd, rs);
        chk(rd, 32'h2);
        axi_wr(8'h3c, 32'h1, rs);
        chk(rs, `I2CT_RESP_SLVERR);
        axi_rd(8'h3c, rd, rs);
        chk(rs, `I2CT_RESP_SLVERR);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task t_busy;
        int n0;
        n0 = oe_cnt;
        axi_wr(A_SCL, 32'h0302, rs);
        axi_rd(A_SCL, rd, rs);
        chk(rd, 32'h0302);
        lpulse(1'b0);
        wait_busy(1'b1);
        chk(link_busy, 1);
        axi_wr(A_SCL, 32'h0a0a, rs);
        chk(rs, `I2CT_RESP_OKAY);
        axi_rd(A_SCL, rd, rs);
        chk(rd, 32'h0302);
        repeat (40) @(posedge mclk);
        axi_rd(A_STA, rd, rs);
        chk(rd[2], 0);
        chk(oe_cnt - n0, 0);
        lpulse(1'b1);
        wait_busy(1'b0);
        chk(link_busy, 0);
        axi_wr(A_SCL, 32'h0909, rs);
        axi_rd(A_SCL, rd, rs);
        chk(rd, 32'h0909);
        $display("test busy done");
    endtask : t_busy
    task t_scl(input logic [31:0] d, input int el, input int eh);
        int lo, hi;
        axi_wr(A_SCL, d, rs);
        axi_wr(A_CTL, 32'h1, rs);
        lpulse(1'b0);
        do @(negedge mclk);
        while (scl_oe !== 1'b1);
        lo = 0;
        hi = 0;
        while (scl_oe === 1'b1) begin
            lo++;
            @(negedge mclk);
        end
        while (scl_oe === 1'b0) begin
            hi++;
            @(negedge mclk);
        end
        chk(lo, el);
        chk(hi, eh);
        chk(link_scl_edges, 1);
        @(posedge mclk);
        rst();
        axi_rd(A_SCL, rd, rs);
        chk(rd, 32'h0204);
        $display("test scl %h done", d);
    endtask : t_scl

    task results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    initial begin
        {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {link_frame_start, link_frame_stop, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
        s_axi_wstrb = 4'hf;
        {error_cnt, check_count, cyc, oe_cnt} = '0;
        rst();
        t_reset();
        t_busy();
        t_scl(32'h0302, 5, 4);
        t_scl(32'hff06, 7, 256);
        t_scl(32'h0204, 5, 3);
        results();
    end
endmodule : testbench

bind i2ct_top i2ct_sva #(.CNT_W(CNT_W)) sva_u (.*);
